//--- rtl/mbcw_device.sv
// Notes on behaviour
// - accept edge interval only inside limit window
// - both limits come from limit settings
// - lower is count, upper is count minus one
// - extended tick is base times 8,4,2,1
// - base tick is crystal divided by 30/28
// - each bit needs two credits: one per passing half interval, two per passing full interval
// - all bits pass: receive, forward data out
// - bad interval: abort at once and sleep in check, flag violation in receive
// - full-period limits: sum minus/plus half difference
// - full-period window judges full-length edge intervals
// - three bits check in about 3.5 periods
// - transmitter sends Manchester coded telegram
// - telegram is preburst, start bit, payload
// - preburst covers sleep, startup and check time
// - software picks window near 25 to 30 percent
// - software derives limits from half-bit period
//
// The address map and the APB interface to the registers were decided locally.
module mbcw_device
  import mbcw_pkg::*;
#(
  parameter int BASE_DIV    = BASE_DIV_LOW_BAND,
  parameter int SLEEP_TICKS = SLEEP_TICKS_DEFAULT
)
(
  input  wire logic   clk,
  input  wire logic   reset,
  mbcw_link_if.device link
);

  localparam int TW = LIM_W + 2;
  localparam int CW = NBITS_W + 2;

  if (BASE_DIV != BASE_DIV_LOW_BAND && BASE_DIV != BASE_DIV_HIGH_BAND)
  begin : g_bad_div
    $error("base divide must be one of the two band variants");
  end
  if (SLEEP_TICKS < 1 || SLEEP_TICKS > 65535)
  begin : g_bad_sleep
    $error("sleep length out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick generation

  logic [4:0] base_cnt;
  logic [2:0] ext_cnt;
  wire        base_tick;
  wire  [3:0] ext_mult;
  wire  [2:0] ext_last;
  wire        extended_tick;

  assign base_tick = base_cnt == 5'(BASE_DIV - 1);
  assign ext_mult  = XTICK_MULT_MAX >> link.rate_range_select;
  assign ext_last  = 3'(ext_mult - 4'h1);
  assign extended_tick = base_tick && (ext_cnt >= ext_last);

  always_ff @(posedge clk)
  begin
    if (reset || base_tick)
      base_cnt <= 5'h00;
    else
      base_cnt <= base_cnt + 5'h01;
  end

  // a range change mid-count only alters one tick, to a length between the old and new ones
  always_ff @(posedge clk)
  begin
    if (reset || extended_tick)
      ext_cnt <= 3'h0;
    else if (base_tick)
      ext_cnt <= ext_cnt + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge interval timer

  logic          line_q;
  logic [TW-1:0] tcnt;
  wire           line_edge;
  wire  [TW-1:0] next_tcnt;

  assign line_edge = link.line != line_q;
  // saturating so a dead line never wraps back into the window
  assign next_tcnt = line_edge ? '0 :
                     (extended_tick && !(&tcnt)) ? tcnt + 1'b1 : tcnt;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      line_q <= 1'b0;
      tcnt   <= '0;
    end
    else
    begin
      line_q <= link.line;
      tcnt   <= next_tcnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // windows

  wire [TW:0] lo_w;
  wire [TW:0] hi_w;
  wire [TW:0] t_w;
  wire [TW:0] t_x2;
  wire [TW:0] full_period_lower_count_x2;
  wire [TW:0] full_period_upper_count_x2;
  wire        half_ok;
  wire        full_ok;
  wire        too_long;

  assign lo_w = (TW+1)'(link.lim_lower);
  assign hi_w = (TW+1)'(link.lim_upper);
  assign t_w  = (TW+1)'(tcnt);
  assign t_x2 = {tcnt, 1'b0};

  // doubled so the half-difference stays exact
  assign full_period_lower_count_x2 = (lo_w << 1) + lo_w + hi_w;
  assign full_period_upper_count_x2 = (hi_w << 1) + hi_w + lo_w;

  assign half_ok  = (t_w >= lo_w) && (t_w + 1'b1 <= hi_w);
  assign full_ok  = (t_x2 >= full_period_lower_count_x2) &&
                    (t_x2 <= full_period_upper_count_x2);
  assign too_long = t_x2 > full_period_upper_count_x2;

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing

  mbcw_rx_state_t state;
  mbcw_rx_state_t next_state;
  logic [CW-1:0]  credits;
  logic [CW-1:0]  next_credits;
  logic           armed;
  logic           next_armed;
  logic [15:0]    sleep_cnt;
  logic [15:0]    next_sleep_cnt;
  logic           next_violation;
  wire  [CW-1:0]  credits_needed;

  // two half-interval credits per Manchester bit
  assign credits_needed = {link.required_bits_count, 1'b0};

  always_comb
  begin
    next_state     = state;
    next_credits   = credits;
    next_armed     = armed;
    next_sleep_cnt = sleep_cnt;
    next_violation = 1'b0;
    case (state)
      RX_SLEEP:
      begin
        if (extended_tick)
        begin
          if (sleep_cnt >= 16'(SLEEP_TICKS - 1))
          begin
            next_state     = RX_CHECK;
            next_sleep_cnt = 16'h0000;
            next_credits   = '0;
            next_armed     = 1'b0;
          end
          else
            next_sleep_cnt = sleep_cnt + 16'h0001;
        end
      end
      RX_CHECK:
      begin
        if (line_edge)
        begin
          if (!armed)
            next_armed = 1'b1;
          else if (half_ok)
            next_credits = credits + CW'(1);
          else if (full_ok)
            next_credits = credits + CW'(2);
          else
            next_state = RX_SLEEP;
        end
        else if (armed && too_long)
          next_state = RX_SLEEP;
        // ends on the last passing edge, about half a bit past n bits
        if (next_state == RX_CHECK && next_credits >= credits_needed
            && next_armed && line_edge)
          next_state = RX_RECEIVE;
      end
      RX_RECEIVE:
      begin
        if (line_edge && !half_ok && !full_ok)
          next_violation = 1'b1;
        if (link.release_rx)
          next_state = RX_SLEEP;
      end
      default:
        next_state = RX_SLEEP;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state     <= RX_SLEEP;
      credits   <= '0;
      armed     <= 1'b0;
      sleep_cnt <= 16'h0000;
    end
    else
    begin
      state     <= next_state;
      credits   <= next_credits;
      armed     <= next_armed;
      sleep_cnt <= next_sleep_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic data_q;
  logic active_q;
  logic violation_q;

  // idle line reads high, as a pulled-up data pin would
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_q      <= 1'b1;
      active_q    <= 1'b0;
      violation_q <= 1'b0;
    end
    else
    begin
      data_q      <= (next_state == RX_RECEIVE) ? link.line : 1'b1;
      active_q    <= next_state == RX_RECEIVE;
      violation_q <= next_violation;
    end
  end

  assign link.data_out  = data_q;
  assign link.rx_active = active_q;
  assign link.violation = violation_q;

endmodule

//--- rtl/mbcw_pkg.sv
package mbcw_pkg;

  // widths shared by both ends of the link
  localparam int LIM_W   = 8;
  localparam int RANGE_W = 2;
  localparam int NBITS_W = 3;

  // base tick divides of the crystal clock, per band variant
  localparam int BASE_DIV_LOW_BAND  = 30;
  localparam int BASE_DIV_HIGH_BAND = 28;

  // extended tick multiplier for rate range 0, halved per range step
  localparam logic [3:0] XTICK_MULT_MAX = 4'h8;

  // polling sleep length in extended ticks
  localparam int SLEEP_TICKS_DEFAULT = 64;

  // transmitted payload length in bits
  localparam int PAYLOAD_BITS = 16;

  // host register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_LIMITS  = 8'h04;
  localparam logic [7:0] REG_TIMING  = 8'h08;
  localparam logic [7:0] REG_PAYLOAD = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_MASK    = 8'h14;

  // field positions
  localparam int CTRL_GO_BIT      = 0;
  localparam int CTRL_RELEASE_BIT = 1;
  localparam int LIM_LOWER_LSB    = 0;
  localparam int LIM_UPPER_LSB    = 8;
  localparam int LIM_RANGE_LSB    = 16;
  localparam int LIM_NBITS_LSB    = 18;
  localparam int TIM_HALF_LSB     = 0;
  localparam int TIM_PRE_LSB      = 16;
  localparam int EVT_TX_DONE      = 0;
  localparam int EVT_WAKE         = 1;
  localparam int EVT_VIOLATION    = 2;
  localparam int EVT_W            = 3;

  // reset values
  localparam logic [31:0] LIMITS_RESET  = 32'h000c2711;
  localparam logic [31:0] TIMING_RESET  = 32'h19000080;
  localparam logic [31:0] PAYLOAD_RESET = 32'h00000000;

  typedef enum logic [1:0] {RX_SLEEP, RX_CHECK, RX_RECEIVE} mbcw_rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_START, TX_DATA} mbcw_tx_state_t;

endpackage

//--- rtl/mbcw_link_if.sv
interface mbcw_link_if;
  import mbcw_pkg::*;

  logic               line;
  logic [LIM_W-1:0]   lim_lower;
  logic [LIM_W-1:0]   lim_upper;
  logic [RANGE_W-1:0] rate_range_select;
  logic [NBITS_W-1:0] required_bits_count;
  logic               release_rx;
  logic               data_out;
  logic               rx_active;
  logic               violation;

  modport device (
    input  line,
    input  lim_lower,
    input  lim_upper,
    input  rate_range_select,
    input  required_bits_count,
    input  release_rx,
    output data_out,
    output rx_active,
    output violation
  );

  modport host (
    output line,
    output lim_lower,
    output lim_upper,
    output rate_range_select,
    output required_bits_count,
    output release_rx,
    input  data_out,
    input  rx_active,
    input  violation
  );
endinterface

//--- rtl/mbcw_host.sv
module mbcw_host
  import mbcw_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   psel,
  input  wire logic   penable,
  input  wire logic   pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output wire logic   pready,
  output wire logic   pslverr,
  output wire logic   irq,
  mbcw_link_if.host   link
);

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic [31:0]      limits;
  logic [31:0]      timing;
  logic [31:0]      payload;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic             rx_q;
  logic             busy;
  wire              access;
  wire              setup;
  wire              wr;
  wire              rd_status;
  wire              mapped;
  wire              go;
  wire  [EVT_W-1:0] events;
  logic [31:0]      rd_value;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign pready = access;
  assign mapped = paddr == REG_CTRL || paddr == REG_LIMITS ||
                  paddr == REG_TIMING || paddr == REG_PAYLOAD ||
                  paddr == REG_STATUS || paddr == REG_MASK;
  assign pslverr = access && !mapped;
  assign wr = access && pwrite && mapped;
  assign rd_status = access && !pwrite && paddr == REG_STATUS;
  assign go = wr && paddr == REG_CTRL && pwdata[CTRL_GO_BIT] && !busy;
  assign link.release_rx = wr && paddr == REG_CTRL &&
                           pwdata[CTRL_RELEASE_BIT];

  always_comb
  begin
    case (paddr)
      REG_CTRL:    rd_value = {30'h0, link.rx_active, busy};
      REG_LIMITS:  rd_value = limits;
      REG_TIMING:  rd_value = timing;
      REG_PAYLOAD: rd_value = payload;
      REG_STATUS:  rd_value = {29'h0, status};
      REG_MASK:    rd_value = {29'h0, mask};
      default:     rd_value = 32'h00000000;
    endcase
  end

  // status is snapshotted at setup; only those bits clear, so a new event wins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prdata  <= 32'h00000000;
      limits  <= LIMITS_RESET;
      timing  <= TIMING_RESET;
      payload <= PAYLOAD_RESET;
      mask    <= '0;
      status  <= '0;
      rx_q    <= 1'b0;
    end
    else
    begin
      if (setup)
        prdata <= rd_value;
      if (wr && paddr == REG_LIMITS)
        limits <= {11'h0, pwdata[20:0]};
      if (wr && paddr == REG_TIMING)
        timing <= {8'h0, pwdata[23:0]};
      if (wr && paddr == REG_PAYLOAD)
        payload <= {16'h0, pwdata[15:0]};
      if (wr && paddr == REG_MASK)
        mask <= pwdata[EVT_W-1:0];
      status <= (rd_status ? status & ~prdata[EVT_W-1:0] : status) | events;
      rx_q   <= link.rx_active;
    end
  end

  assign irq = |(status & mask);

  assign link.lim_lower = limits[LIM_LOWER_LSB +: LIM_W];
  assign link.lim_upper = limits[LIM_UPPER_LSB +: LIM_W];
  assign link.rate_range_select   = limits[LIM_RANGE_LSB +: RANGE_W];
  assign link.required_bits_count = limits[LIM_NBITS_LSB +: NBITS_W];

  ////////////////////////////////////////////////////////////////////////////
  // telegram transmitter

  mbcw_tx_state_t tx_state;
  logic [15:0]    half_cnt;
  logic           second_half;
  logic [7:0]     bit_cnt;
  logic [15:0]    shreg;
  logic           line_q;
  logic           done_q;
  wire            half_end;
  wire            bit_end;
  wire            cur_bit;
  wire  [15:0]    half_period;
  wire  [7:0]     preburst_bits;

  assign half_period   = timing[TIM_HALF_LSB +: 16];
  assign preburst_bits = timing[TIM_PRE_LSB +: 8];
  assign half_end = 17'(half_cnt) + 17'h1 >= {1'b0, half_period};
  assign bit_end  = half_end && second_half;
  assign busy     = tx_state != TX_IDLE;
  assign cur_bit  = (tx_state == TX_PRE) ? 1'b1 :
                    (tx_state == TX_START) ? 1'b0 : shreg[15];

  always_ff @(posedge clk)
  begin
    if (reset || go || !busy || half_end)
      half_cnt <= 16'h0000;
    else
      half_cnt <= half_cnt + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_state    <= TX_IDLE;
      second_half <= 1'b0;
      bit_cnt     <= 8'h00;
      shreg       <= 16'h0000;
      done_q      <= 1'b0;
      line_q      <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (go)
      begin
        tx_state    <= TX_PRE;
        second_half <= 1'b0;
        bit_cnt     <= 8'h00;
        shreg       <= payload[PAYLOAD_BITS-1:0];
      end
      else if (busy && half_end)
      begin
        second_half <= !second_half;
        if (bit_end)
        begin
          bit_cnt <= bit_cnt + 8'h01;
          case (tx_state)
            TX_PRE:
              if (bit_cnt + 8'h01 >= preburst_bits)
                tx_state <= TX_START;
            TX_START:
            begin
              tx_state <= TX_DATA;
              bit_cnt  <= 8'h00;
            end
            TX_DATA:
            begin
              shreg <= {shreg[14:0], 1'b0};
              if (bit_cnt == 8'(PAYLOAD_BITS - 1))
              begin
                tx_state <= TX_IDLE;
                done_q   <= 1'b1;
              end
            end
            default:
              tx_state <= TX_IDLE;
          endcase
        end
      end
      line_q <= busy ? (second_half ? !cur_bit : cur_bit) : 1'b0;
    end
  end

  assign link.line = line_q;
  assign events = {link.violation, link.rx_active && !rx_q, done_q};

endmodule

//--- testbench/mbcw_properties.sv
module mbcw_properties
  import mbcw_pkg::*;
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               line,
  input wire logic [NBITS_W-1:0] required_bits_count,
  input wire logic               release_rx,
  input wire logic               data_out,
  input wire logic               rx_active,
  input wire logic               violation
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       line_q;
  logic [3:0] quiet;
  logic [7:0] edges;

  // quiet saturates so a long idle line never wraps into a false recent edge
  always_ff @(posedge clk)
  begin
    line_q <= line;
    quiet  <= reset ? 4'hf : (line != line_q) ? 4'h0 :
              quiet + {3'h0, quiet != 4'hf};
    edges  <= (reset || rx_active) ? 8'h00 :
              edges + {7'h0, line != line_q && edges != 8'hff};
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_data_idle: assert property (
    !rx_active && !$past(rx_active) |-> data_out)
    else $error("data output not idle high outside receive");
  chk_data_follow: assert property (
    rx_active && $past(rx_active) |-> data_out == $past(line))
    else $error("data output does not follow the line");
  chk_release_drop: assert property (
    rx_active && release_rx |=> !rx_active)
    else $error("receive kept after release");
  chk_active_hold: assert property (
    rx_active && !release_rx |=> rx_active)
    else $error("receive dropped without release");
  chk_violation_pulse: assert property (
    violation |=> !violation)
    else $error("violation longer than one cycle");
  chk_violation_rx: assert property (
    violation |-> rx_active || $past(rx_active))
    else $error("violation outside receive");
  // the wake decision is taken on an edge, so one must be recent
  chk_wake_edge: assert property (
    $rose(rx_active) |-> quiet < 4'h6)
    else $error("wake without a recent edge");
  chk_wake_count: assert property (
    $rose(rx_active) |-> edges > {5'h00, required_bits_count})
    else $error("wake after too few edges");

  cov_wake: cover property ($rose(rx_active));
  cov_violation: cover property (violation);
  cov_release: cover property (rx_active && release_rx);
endmodule

//--- testbench/tb.sv
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end

module tb
  import mbcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, irq, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'he689;
  int          err_count = 0, cmp_count = 0, b;
  logic [7:0]  ra [5] = '{REG_LIMITS, REG_TIMING, REG_PAYLOAD, REG_STATUS,
                          REG_MASK};
  logic [31:0] rv [5] = '{LIMITS_RESET, TIMING_RESET, PAYLOAD_RESET,
                          32'h0, 32'h0};
  int          fr [3] = '{0, 3, 3}, flo [3] = '{3, 6, 3}, fup [3] = '{6, 9, 4};

  mbcw_link_if link ();
  mbcw_host mbcw_host_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(link));
  // short sleep keeps each polling round cheap in simulation
  mbcw_device #(.BASE_DIV(BASE_DIV_HIGH_BAND), .SLEEP_TICKS(2))
    mbcw_device_i (.clk(clk), .reset(reset), .link(link));
  mbcw_properties mbcw_properties_i (.clk(clk), .reset(reset),
    .line(link.line), .required_bits_count(link.required_bits_count),
    .release_rx(link.release_rx), .data_out(link.data_out),
    .rx_active(link.rx_active), .violation(link.violation));

  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // half bit of 4.5 extended ticks sits mid window for limits 3 and 6
  function int half_len(int r);
    return 9 * BASE_DIV_HIGH_BAND * (8 >> r) / 2;
  endfunction

  function logic [31:0] exp_status(logic w, logic v);
    return {29'h0, v, w, 1'b1};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // four preburst bits, then start bit and payload: 21 bits per telegram
  task automatic send(int r, int nb, int lo, int up, int hl);
    int n;
    n = 0;
    apb(1'b1, REG_LIMITS, 32'(lo) | 32'(up) << LIM_UPPER_LSB |
        32'(r) << LIM_RANGE_LSB | 32'(nb) << LIM_NBITS_LSB);
    apb(1'b1, REG_TIMING, 32'(hl) | 32'h00040000);
    apb(1'b1, REG_PAYLOAD, xs() & 32'h0000ffff);
    apb(1'b1, REG_CTRL, 32'h1);
    do
    begin
      apb(1'b0, REG_CTRL, 32'h0);
      n++;
    end
    while (rd[CTRL_GO_BIT] !== 1'b0 && n < 20000);
    `CHK(rd[CTRL_GO_BIT], 1'b0)
    repeat (8) @(posedge clk);
  endtask

  task end_of_test;
    $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 clk = ~clk;
  end

  initial
  begin
    // seven telegrams need about 70,000 cycles; the rest is margin
    repeat (90000) @(posedge clk);
    err_count++;
    end_of_test;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    foreach (ra[i])
      chk_rd(ra[i], rv[i]);
    apb(1'b0, 8'h18, 32'hffffffff);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, REG_MASK, 32'h6);
    for (int r = 3; r >= 1; r--)
    begin
      b = 1 + int'(xs() % 3);
      send(r, b, 3, 6, half_len(r));
      `CHK(link.rx_active, 1'b1)
      `CHK(irq, 1'b1)
      chk_rd(REG_STATUS, exp_status(1'b1, 1'b0));
      // the clear lands at the access edge, so look one edge later
      @(posedge clk);
      `CHK(irq, 1'b0)
      if (r == 3)
      begin
        // triple length misses both windows while receiving
        send(3, b, 3, 6, 3 * half_len(3));
        chk_rd(REG_STATUS, exp_status(1'b0, 1'b1));
      end
      apb(1'b1, REG_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      `CHK(link.rx_active, 1'b0)
    end
    // slow range, lower limit above and upper limit below the interval
    foreach (fr[i])
    begin
      send(fr[i], 3, flo[i], fup[i], half_len(3));
      `CHK(link.rx_active, 1'b0)
      chk_rd(REG_STATUS, exp_status(1'b0, 1'b0));
      @(posedge clk);
      `CHK(irq, 1'b0)
    end
    end_of_test;
  end
endmodule
